// ### hw/sicl_pkg.sv
package sicl_pkg;

    // ========================================================================
    // timing
    // ========================================================================
    localparam int unsigned CLK_PERIOD_NS    = 8;
    localparam int unsigned SAMPLE_PERIOD_US = 10_000;
    localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SAMPLES_PER_SEC  = 1_000_000 / SAMPLE_PERIOD_US;
    localparam int unsigned PCT_FULL         = 10000;

    // ========================================================================
    // register byte offsets
    // ========================================================================
    localparam logic [5:0] OFS_CTRL       = 6'h00;
    localparam logic [5:0] OFS_LOG_PERIOD = 6'h04;
    localparam logic [5:0] OFS_TRIG_CFG   = 6'h08;
    localparam logic [5:0] OFS_THR_A      = 6'h0c;
    localparam logic [5:0] OFS_THR_B      = 6'h10;
    localparam logic [5:0] OFS_DATAPOINT  = 6'h14;
    localparam logic [5:0] OFS_STATUS     = 6'h18;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h1c;
    localparam logic [5:0] OFS_IRQ_MASK   = 6'h20;

    // ========================================================================
    // field positions and reset values
    // ========================================================================
    localparam int unsigned STAT_RAW_PIN  = 0;
    localparam int unsigned STAT_TRIG_HIT = 1;
    localparam int unsigned IRQ_DP        = 0;
    localparam int unsigned IRQ_ALARM     = 1;
    localparam int unsigned IRQ_W         = 2;

    localparam logic [15:0] RST_LOG_PERIOD = 16'h012c;
    localparam logic [3:0]  RST_TRIG_C     = 4'h1;
    localparam logic [3:0]  RST_TRIG_D     = 4'h1;

    // ========================================================================
    // types
    // ========================================================================
    typedef enum logic [1:0] {
        SICL_SPOT,
        SICL_SECS,
        SICL_PCT_CLOSED,
        SICL_PCT_OPEN
    } sicl_mode_t;

    typedef enum logic [1:0] {
        SICL_TRIG_OFF,
        SICL_TRIG_ABOVE,
        SICL_TRIG_BELOW,
        SICL_TRIG_BETWEEN
    } sicl_trig_t;

    typedef struct packed {
        logic       invert;
        sicl_mode_t mode;
        logic       enable;
    } sicl_ctrl_t;

    typedef struct packed {
        logic [3:0] depth_d;
        logic [3:0] count_c;
        logic [1:0] pad;
        sicl_trig_t kind;
    } sicl_trig_cfg_t;

endpackage

// ### hw/sicl_trigger.sv
module sicl_trigger #(
    parameter int unsigned DEPTH = 8
) (
    input  wire logic                    clock_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    eval_i,
    input  wire logic [31:0]             value_i,
    input  wire sicl_pkg::sicl_trig_cfg_t cfg_i,
    input  wire logic [31:0]             thr_a_i,
    input  wire logic [31:0]             thr_b_i,
    output logic                         hit_o,
    output logic                         fire_o
);

    logic [DEPTH-1:0] hist;
    logic [DEPTH-1:0] next_hist;
    logic             next_hit;
    logic             next_fire;
    logic             match;
    logic [4:0]       ones;

    // counts qualifying datapoints among the last d entries
    function automatic logic [4:0] count_last(input logic [DEPTH-1:0] h, input logic [3:0] d);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < DEPTH; i++) begin
            if (i < int'(d) && h[i]) begin
                n = n + 5'h01;
            end
        end
        return n;
    endfunction

    // ========================================================================
    // comparison and c-of-d qualification
    // ========================================================================
    always_comb begin
        case (cfg_i.kind)
            sicl_pkg::SICL_TRIG_ABOVE:   match = value_i > thr_a_i;
            sicl_pkg::SICL_TRIG_BELOW:   match = value_i < thr_a_i;
            sicl_pkg::SICL_TRIG_BETWEEN: match = value_i >= thr_a_i && value_i <= thr_b_i;
            default:                     match = 1'b0;
        endcase
        next_hist = hist;
        next_hit  = hit_o;
        next_fire = 1'b0;
        ones      = 5'h00;
        if (eval_i) begin
            next_hist = {hist[DEPTH-2:0], match};
            ones      = count_last(next_hist, cfg_i.depth_d);
            next_hit  = cfg_i.kind != sicl_pkg::SICL_TRIG_OFF && cfg_i.count_c != 4'h0
                        && ones >= {1'b0, cfg_i.count_c};
            next_fire = next_hit && !hit_o;
        end
    end

    // history and outputs
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hist   <= '0;
            hit_o  <= 1'b0;
            fire_o <= 1'b0;
        end else begin
            hist   <= next_hist;
            hit_o  <= next_hit;
            fire_o <= next_fire;
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    hit_on_boundary_a: assert property (!eval_i |=> $stable(hit_o))
        else $error("trigger state moved without a log boundary");
    fire_follows_eval_a: assert property (fire_o |-> $past(eval_i) && hit_o && !$past(hit_o))
        else $error("alarm fired outside a log boundary");
    single_point_a: assert property ((eval_i && match && cfg_i.count_c == 4'h1 && cfg_i.depth_d == 4'h1
                                      && cfg_i.kind != sicl_pkg::SICL_TRIG_OFF) |=> hit_o)
        else $error("one qualifying datapoint did not trigger with c=d=1");
    between_limits_a: assert property ((eval_i && cfg_i.kind == sicl_pkg::SICL_TRIG_BETWEEN
                                        && cfg_i.count_c == 4'h1 && cfg_i.depth_d == 4'h1
                                        && (value_i < thr_a_i || value_i > thr_b_i)) |=> !hit_o)
        else $error("between trigger held outside its limits");
    fire_c: cover property (eval_i ##1 fire_o);

endmodule

// ### hw/sicl_logger.sv
// Contract
// - status unit with spot mode logs each period as a single bit.
// - inverted spot option flips the sampled pin before the datapoint is formed.
// - hardware test view shows the raw pin, never inverted, in any mode.
// - seconds unit counts seconds at logic one; counter clears at each datapoint; the code also applies invert, counting logic zero when set.
// - seconds datapoint never exceeds the log period in seconds.
// - percentage modes scale time in chosen state to 0..10000.
// - time closed gives 0 always open, 10000 always closed; time open opposite.
// - triggers are evaluated on new datapoints only at log boundaries.
// - trigger is true when at least c of the last d datapoints qualify.
// - between trigger fires when the value lies within both limits.
// - a triggered condition raises an alarm, compared on the logged datapoint.
//
// Our own choices: the register offsets and the Avalon-MM register port.
module sicl_logger #(
    parameter int unsigned TICK_CYCLES = sicl_pkg::SAMPLE_CYCLES,
    parameter int unsigned SPS         = sicl_pkg::SAMPLES_PER_SEC,
    parameter int unsigned HIST_DEPTH  = 8
) (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        pin_closed_i,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq_o
);

    // ========================================================================
    // registers and state
    // ========================================================================
    sicl_pkg::sicl_ctrl_t     ctrl,       next_ctrl;
    logic [15:0]              log_period, next_log_period;
    sicl_pkg::sicl_trig_cfg_t trig_cfg,   next_trig_cfg;
    logic [31:0]              thr_a,      next_thr_a;
    logic [31:0]              thr_b,      next_thr_b;
    logic [1:0]               irq_stat,   next_irq_stat;
    logic [1:0]               irq_mask,   next_irq_mask;
    logic                     ack,        next_ack;
    logic [31:0]              rdata,      next_rdata;

    logic [31:0]              tick_cnt,   next_tick_cnt;
    logic [15:0]              samp_cnt,   next_samp_cnt;
    logic [15:0]              sec_cnt,    next_sec_cnt;
    logic [31:0]              on_cnt,     next_on_cnt;
    logic                     pin_q,      next_pin_q;
    logic [31:0]              dp,         next_dp;
    logic                     dp_stb,     next_dp_stb;
    logic                     all_on,     next_all_on;

    logic                     tick;
    logic                     cond;
    logic                     boundary;
    logic [31:0]              on_total;
    logic [31:0]              period_eff;
    logic [31:0]              samp_total;
    logic                     trig_hit;
    logic                     trig_fire;
    logic                     bus_req;

    // floor quotient limited to a ceiling
    function automatic logic [31:0] sat_div(input logic [47:0] num, input logic [31:0] den,
                                            input logic [31:0] lim);
        logic [47:0] q;
        q = (den == 32'h0000_0000) ? 48'h0000_0000_0000 : num / {16'h0000, den};
        return (q > {16'h0000, lim}) ? lim : q[31:0];
    endfunction

    // ========================================================================
    // sampling, seconds and datapoint formation
    // ========================================================================
    // one tick per sample, SPS samples make a second, log period seconds make a boundary;
    // seconds and percentages both come from the same samples, so they always agree
    assign tick       = tick_cnt == TICK_CYCLES - 1;
    assign period_eff = (log_period == 16'h0000) ? 32'h0000_0001 : {16'h0000, log_period};
    assign samp_total = 32'(period_eff * SPS);

    always_comb begin
        // condition counted this sample
        case (ctrl.mode)
            sicl_pkg::SICL_PCT_CLOSED: cond = pin_closed_i;
            sicl_pkg::SICL_PCT_OPEN:   cond = !pin_closed_i;
            default:                   cond = pin_closed_i ^ ctrl.invert;
        endcase
        // a period shortened mid-count must still end, so the seconds test is >= not ==
        boundary        = tick && samp_cnt == 16'(SPS - 1) && {16'h0000, sec_cnt} >= period_eff - 32'h0000_0001;
        on_total        = on_cnt + {31'h0000_0000, cond};
        next_tick_cnt   = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        next_samp_cnt   = samp_cnt;
        next_sec_cnt    = sec_cnt;
        next_on_cnt     = on_cnt;
        next_pin_q      = pin_q;
        next_dp         = dp;
        next_dp_stb     = 1'b0;
        next_all_on     = all_on;
        if (!ctrl.enable) begin
            next_tick_cnt = 32'h0000_0000;
            next_samp_cnt = 16'h0000;
            next_sec_cnt  = 16'h0000;
            next_on_cnt   = 32'h0000_0000;
        end else if (tick) begin
            next_pin_q    = pin_closed_i;
            next_on_cnt   = on_total;
            next_samp_cnt = (samp_cnt == 16'(SPS - 1)) ? 16'h0000 : samp_cnt + 16'h0001;
            if (samp_cnt == 16'(SPS - 1)) begin
                next_sec_cnt = sec_cnt + 16'h0001;
            end
            if (boundary) begin
                next_sec_cnt = 16'h0000;
                next_on_cnt  = 32'h0000_0000;
                next_dp_stb  = 1'b1;
                next_all_on  = on_total == samp_total;
                case (ctrl.mode)
                    sicl_pkg::SICL_SPOT: begin
                        next_dp = {31'h0000_0000, pin_closed_i ^ ctrl.invert};
                    end
                    sicl_pkg::SICL_SECS: begin
                        next_dp = sat_div({16'h0000, on_total}, SPS, period_eff);
                    end
                    default: begin
                        next_dp = sat_div(48'(on_total) * 48'(sicl_pkg::PCT_FULL), samp_total,
                                          32'(sicl_pkg::PCT_FULL));
                    end
                endcase
            end
        end
    end

    // sampling registers
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt <= 32'h0000_0000;
            samp_cnt <= 16'h0000;
            sec_cnt  <= 16'h0000;
            on_cnt   <= 32'h0000_0000;
            pin_q    <= 1'b0;
            dp       <= 32'h0000_0000;
            dp_stb   <= 1'b0;
            all_on   <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            samp_cnt <= next_samp_cnt;
            sec_cnt  <= next_sec_cnt;
            on_cnt   <= next_on_cnt;
            pin_q    <= next_pin_q;
            dp       <= next_dp;
            dp_stb   <= next_dp_stb;
            all_on   <= next_all_on;
        end
    end

    // ========================================================================
    // trigger on each logged datapoint
    // ========================================================================
    // the strobe follows the boundary by one edge, so the trigger sees the datapoint
    // just stored and its verdict lands one edge after that
    sicl_trigger #(
        .DEPTH   (HIST_DEPTH)
    ) u_trigger (
        .clock_i (clock_i),
        .sys_rst_i(sys_rst_i),
        .eval_i  (dp_stb),
        .value_i (dp),
        .cfg_i   (trig_cfg),
        .thr_a_i (thr_a),
        .thr_b_i (thr_b),
        .hit_o   (trig_hit),
        .fire_o  (trig_fire)
    );

    // ========================================================================
    // avalon-mm slave, one wait state per access
    // ========================================================================
    // register map, byte offsets:
    //   0x00 control: enable, mode, invert
    //   0x04 log period in seconds, zero taken as one
    //   0x08 trigger kind, count c, depth d
    //   0x0c and 0x10 lower and upper thresholds
    //   0x14 last datapoint, read only
    //   0x18 raw pin and trigger state, read only
    //   0x1c event flags, write one to clear, a same-cycle event wins
    //   0x20 event mask
    //   other offsets read zero, ignore writes and still answer
    assign bus_req         = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !ack;
    assign avs_readdata    = rdata;
    assign irq_o           = |(irq_stat & irq_mask);

    always_comb begin
        next_ack        = bus_req && !ack;
        next_ctrl       = ctrl;
        next_log_period = log_period;
        next_trig_cfg   = trig_cfg;
        next_thr_a      = thr_a;
        next_thr_b      = thr_b;
        next_irq_mask   = irq_mask;
        next_irq_stat   = irq_stat;
        next_rdata      = rdata;
        // first cycle of a read: capture the answer
        if (avs_read && !ack) begin
            case (avs_address)
                sicl_pkg::OFS_CTRL:       next_rdata = {28'h000_0000, ctrl};
                sicl_pkg::OFS_LOG_PERIOD: next_rdata = {16'h0000, log_period};
                sicl_pkg::OFS_TRIG_CFG:   next_rdata = {20'h0_0000, trig_cfg};
                sicl_pkg::OFS_THR_A:      next_rdata = thr_a;
                sicl_pkg::OFS_THR_B:      next_rdata = thr_b;
                sicl_pkg::OFS_DATAPOINT:  next_rdata = dp;
                sicl_pkg::OFS_STATUS:     next_rdata = {30'h0000_0000, trig_hit, pin_q};
                sicl_pkg::OFS_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_stat};
                sicl_pkg::OFS_IRQ_MASK:   next_rdata = {30'h0000_0000, irq_mask};
                default:                  next_rdata = 32'h0000_0000;
            endcase
        end
        // write takes effect on the edge that completes it
        if (avs_write && ack) begin
            case (avs_address)
                sicl_pkg::OFS_CTRL:       next_ctrl       = sicl_pkg::sicl_ctrl_t'(avs_writedata[3:0]);
                sicl_pkg::OFS_LOG_PERIOD: next_log_period = avs_writedata[15:0];
                sicl_pkg::OFS_TRIG_CFG:   next_trig_cfg   = sicl_pkg::sicl_trig_cfg_t'(avs_writedata[11:0]);
                sicl_pkg::OFS_THR_A:      next_thr_a      = avs_writedata;
                sicl_pkg::OFS_THR_B:      next_thr_b      = avs_writedata;
                sicl_pkg::OFS_IRQ_STATUS: next_irq_stat   = irq_stat & ~avs_writedata[1:0];
                sicl_pkg::OFS_IRQ_MASK:   next_irq_mask   = avs_writedata[1:0];
                default:                  next_ack        = 1'b0;
            endcase
        end
        // events set after the clear so a same-cycle event wins
        next_irq_stat[sicl_pkg::IRQ_DP]    = next_irq_stat[sicl_pkg::IRQ_DP] | dp_stb;
        next_irq_stat[sicl_pkg::IRQ_ALARM] = next_irq_stat[sicl_pkg::IRQ_ALARM] | trig_fire;
    end

    // register file
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack        <= 1'b0;
            ctrl       <= '{invert: 1'b0, mode: sicl_pkg::SICL_SPOT, enable: 1'b0};
            log_period <= sicl_pkg::RST_LOG_PERIOD;
            trig_cfg   <= '{depth_d: sicl_pkg::RST_TRIG_D, count_c: sicl_pkg::RST_TRIG_C,
                            pad: 2'h0, kind: sicl_pkg::SICL_TRIG_OFF};
            thr_a      <= 32'h0000_0000;
            thr_b      <= 32'h0000_0000;
            irq_stat   <= 2'h0;
            irq_mask   <= 2'h0;
            rdata      <= 32'h0000_0000;
        end else begin
            ack        <= next_ack;
            ctrl       <= next_ctrl;
            log_period <= next_log_period;
            trig_cfg   <= next_trig_cfg;
            thr_a      <= next_thr_a;
            thr_b      <= next_thr_b;
            irq_stat   <= next_irq_stat;
            irq_mask   <= next_irq_mask;
            rdata      <= next_rdata;
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    spot_binary_a: assert property ((dp_stb && $past(ctrl.mode) == sicl_pkg::SICL_SPOT)
                                    |-> dp <= 32'h0000_0001)
        else $error("spot datapoint is not a single bit");
    spot_invert_a: assert property ((boundary && ctrl.mode == sicl_pkg::SICL_SPOT && ctrl.enable)
                                    |=> dp[0] == ($past(pin_closed_i) ^ $past(ctrl.invert)))
        else $error("spot datapoint ignores the inversion option");
    raw_status_a: assert property ((avs_read && !ack && avs_address == sicl_pkg::OFS_STATUS)
                                   |=> avs_readdata[0] == $past(pin_q))
        else $error("status view is not the raw pin");
    secs_clear_a: assert property (dp_stb |-> on_cnt == 32'h0000_0000 && sec_cnt == 16'h0000)
        else $error("seconds accumulator not cleared at datapoint");
    secs_limit_a: assert property ((dp_stb && $past(ctrl.mode) == sicl_pkg::SICL_SECS)
                                   |-> dp <= $past(period_eff))
        else $error("seconds datapoint exceeds log period");
    pct_range_a: assert property ((dp_stb && $past(ctrl.mode[1])) |-> dp <= 32'(sicl_pkg::PCT_FULL))
        else $error("percentage datapoint beyond full scale");
    pct_full_a: assert property ((dp_stb && $past(ctrl.mode[1]) && all_on)
                                 |-> dp == 32'(sicl_pkg::PCT_FULL))
        else $error("full-period condition did not give full scale");
    alarm_irq_a: assert property (trig_fire |=> irq_stat[sicl_pkg::IRQ_ALARM])
        else $error("trigger fired without raising the alarm flag");
    tick_span_a: assert property (tick |=> !tick [*2])
        else $error("sample ticks closer than the tick period");
    dp_flag_a: assert property (dp_stb |=> irq_stat[sicl_pkg::IRQ_DP])
        else $error("new datapoint did not raise its event flag");
    alarm_clear_a: assert property ((avs_write && ack && avs_address == sicl_pkg::OFS_IRQ_STATUS
                                     && avs_writedata[sicl_pkg::IRQ_ALARM] && !trig_fire)
                                    |=> !irq_stat[sicl_pkg::IRQ_ALARM])
        else $error("writing one did not clear the alarm flag");

    secs_dp_c:  cover property (dp_stb && ctrl.mode == sicl_pkg::SICL_SECS);
    pct_dp_c:   cover property (dp_stb && ctrl.mode == sicl_pkg::SICL_PCT_OPEN);
    alarm_c:    cover property (trig_fire ##1 irq_o);
    spot_inv_c: cover property (dp_stb && ctrl.mode == sicl_pkg::SICL_SPOT && ctrl.invert);

endmodule

// ### sim/sicl_switch_model.sv
// ============================================================================
// switch contact on the status pin
// ============================================================================
module sicl_switch_model (
    input  wire logic clock_i,
    input  wire logic close_i,
    output logic      pin_closed_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // contact follows the commanded position one edge later
    always_ff @(posedge clock_i) begin
        pin_closed_o <= close_i;
    end
endmodule

// ### sim/test_status_input_channel_logger.sv
module test_status_input_channel_logger;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // signals and instances
    // ========================================================================
    logic        clock_i       = 1'b0;
    logic        sys_rst_i     = 1'b1;
    logic        close_cmd     = 1'b0;
    logic        pin_closed;
    logic [5:0]  avs_address   = 6'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq_o;
    int          miscompares   = 0;
    int          n_compared    = 0;

    // mode table: ctrl, pin, expected datapoint with a two second period
    localparam logic [3:0]  CTL [10] = '{4'h1, 4'h9, 4'h9, 4'h3, 4'h3, 4'hb, 4'h5, 4'h5, 4'h7, 4'hf};
    localparam logic        PIN [10] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    localparam logic [15:0] EXP [10] = '{16'h0001, 16'h0000, 16'h0001, 16'h0002, 16'h0000,
                                         16'h0002, 16'h2710, 16'h0000, 16'h2710, 16'h0000};

    // clock at 125 MHz
    always #4 clock_i = ~clock_i;

    sicl_switch_model u_sicl_switch_model (.clock_i(clock_i), .close_i(close_cmd), .pin_closed_o(pin_closed));

    sicl_logger #(.TICK_CYCLES(4), .SPS(2), .HIST_DEPTH(8)) u_sicl_logger (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .pin_closed_i(pin_closed), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));

    // ========================================================================
    // checking and bus tasks
    // ========================================================================
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic timed_out();
        miscompares++;
        $display("ERROR at %0t: wait limit, seen %h expected %h", $time, 1'b0, 1'b1);
        print_verdict();
    endtask

    // one access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        // values read right after the edge are those the edge sampled
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        if (n >= 20) timed_out();
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q & m, e);
    endtask

    task automatic irq_chk(input logic e);
        @(negedge clock_i);
        check({31'h0000_0000, irq_o}, {31'h0000_0000, e});
        @(posedge clock_i);
    endtask

    // clear the datapoint flag and wait for the next one, three times
    task automatic settle();
        int n;
        repeat (3) begin
            wr(sicl_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
            n = 0;
            do begin
                @(negedge clock_i);
                n++;
            end while (irq_o !== 1'b1 && n < 200);
            if (n >= 200) timed_out();
            @(posedge clock_i);
        end
    endtask

    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic reset_values();
        rd_chk(sicl_pkg::OFS_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(sicl_pkg::OFS_LOG_PERIOD, 32'hffff_ffff, 32'h0000_012c);
        rd_chk(sicl_pkg::OFS_TRIG_CFG, 32'hffff_ffff, 32'h0000_0110);
        rd_chk(sicl_pkg::OFS_DATAPOINT, 32'hffff_ffff, 32'h0000_0000);
        wr(6'h3c, 32'hffff_ffff);
        rd_chk(6'h3c, 32'hffff_ffff, 32'h0000_0000);
    endtask

    task automatic mode_table();
        wr(sicl_pkg::OFS_LOG_PERIOD, 32'h0000_0002);
        wr(sicl_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        for (int i = 0; i < 10; i++) begin
            close_cmd <= PIN[i];
            wr(sicl_pkg::OFS_CTRL, {28'h000_0000, CTL[i]});
            settle();
            rd_chk(sicl_pkg::OFS_DATAPOINT, 32'hffff_ffff, {16'h0000, EXP[i]});
            rd_chk(sicl_pkg::OFS_STATUS, 32'h0000_0001, {31'h0000_0000, PIN[i]});
        end
    endtask

    // between thresholds first above the datapoint range (3..4), then inside it (1..2)
    task automatic trigger_alarm();
        close_cmd <= 1'b0;
        wr(sicl_pkg::OFS_CTRL, 32'h0000_0001);
        wr(sicl_pkg::OFS_TRIG_CFG, 32'h0000_0111);
        wr(sicl_pkg::OFS_THR_A, 32'h0000_0000);
        settle();
        rd_chk(sicl_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
        rd_chk(sicl_pkg::OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0000);
        close_cmd <= 1'b1;
        settle();
        rd_chk(sicl_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        rd_chk(sicl_pkg::OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
        wr(sicl_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        irq_chk(1'b1);
        wr(sicl_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
        irq_chk(1'b0);
        wr(sicl_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        wr(sicl_pkg::OFS_CTRL, 32'h0000_0003);
        wr(sicl_pkg::OFS_TRIG_CFG, 32'h0000_0113);
        wr(sicl_pkg::OFS_THR_A, 32'h0000_0003);
        wr(sicl_pkg::OFS_THR_B, 32'h0000_0004);
        settle();
        rd_chk(sicl_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
        wr(sicl_pkg::OFS_THR_A, 32'h0000_0001);
        wr(sicl_pkg::OFS_THR_B, 32'h0000_0002);
        settle();
        rd_chk(sicl_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    endtask

    // reset for four cycles, then run every scenario
    initial begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        reset_values();
        mode_table();
        trigger_alarm();
        print_verdict();
    end
endmodule
